// >>> pkg/tws_params.svh
// constants for the two-wire slave receiver: offsets, bits, codes
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
// =============================================
// register byte offsets
`define TWS_OFS_CTRL      8'h00
`define TWS_OFS_STAT      8'h04
`define TWS_OFS_DATA      8'h08
`define TWS_OFS_ADDR      8'h0C
`define TWS_OFS_ISTAT     8'h10
`define TWS_OFS_IMASK     8'h14
// =============================================
// control register bit positions
`define TWS_CTRL_FLAG     7
`define TWS_CTRL_ACK      6
`define TWS_CTRL_STA      5
`define TWS_CTRL_STO      4
`define TWS_CTRL_EN       2
// status register layout
`define TWS_STAT_HI       7
`define TWS_STAT_LO       3
`define TWS_PRESC_HI      1
// =============================================
// status codes, prescaler bits zero
`define TWS_SC_IDLE       8'hF8
`define TWS_SC_OWN_W      8'h60
`define TWS_SC_ARB_OWN_W  8'h68
`define TWS_SC_GC         8'h70
`define TWS_SC_ARB_GC     8'h78
`define TWS_SC_RX_ACK     8'h80
`define TWS_SC_RX_NACK    8'h88
`define TWS_SC_GC_ACK     8'h90
`define TWS_SC_GC_NACK    8'h98
`define TWS_SC_OWN_R      8'hA8
`define TWS_SC_ARB_OWN_R  8'hB0
`define TWS_SC_TX_ACK     8'hB8
`define TWS_SC_TX_NACK    8'hC0
`define TWS_SC_TX_LAST    8'hC8
// =============================================
// misc values
`define TWS_GC_ADDR       7'h00
`define TWS_LAST_BIT      4'h7
`define TWS_ACK_BIT       4'h8
`define TWS_ACK_END       4'h9
`define TWS_CNT_ZERO      4'h0
`define TWS_CNT_ONE       4'h1
`define TWS_RST_BYTE      8'h00
`define TWS_RST_IRQ       3'h0
`define TWS_IRQ_FLAG      0
`define TWS_IRQ_STOP      1
`define TWS_IRQ_WAKE      2
`endif

// >>> pkg/tws_pkg.sv
// types shared by the two-wire slave receiver files
package tws_pkg;
	typedef logic [7:0]  tws_byte_t;
	typedef logic [31:0] tws_word_t;
	typedef logic [2:0]  tws_irq_t;
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_ADDR,
		ST_ACK,
		ST_WAIT,
		ST_RX,
		ST_TX,
		ST_TACK
	} tws_state_e;
endpackage : tws_pkg

// >>> verilog/tws_sync.sv
// two-flop synchroniser for a bus pin with edge pulses
`timescale 1ns/1ps
module tws_sync
(
	input  wire logic sys_clk,
	input  wire logic arst_n,
	input  wire logic ce,
	input  wire logic pinIn,
	output wire logic level,
	output wire logic rise,
	output wire logic fall
);
	logic metaQ;
	logic syncQ;
	logic prevQ;

	// =============================================
	// synchroniser; metaQ feeds only syncQ
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			metaQ <= 1'b1;
			syncQ <= 1'b1;
			prevQ <= 1'b1;
		end
		else if (ce)
		begin
			metaQ <= pinIn;
			syncQ <= metaQ;
			prevQ <= syncQ;
		end
	end

	// edges seen on the settled copy only
	assign level = syncQ;
	assign rise  = syncQ & ~prevQ;
	assign fall  = ~syncQ & prevQ;
endmodule : tws_sync

// >>> verilog/tws_slave.sv
// two-wire bus slave receiver/transmitter with APB registers
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "tws_params.svh"

// Functional notes
// - own bus address is the upper seven bits of the slave address register
// - address register bit 0 enables answering general call address zero
// - matched address with direction 0 receives, direction 1 transmits
// - own address plus write sets the flag and a valid status code
// - arbitration lost then addressed enters receive, codes 0x68 or 0x78
// - ack enable cleared mid-transfer gives NACK after the next byte
// - ack enable zero ignores own address but keeps watching the bus
// - in deep sleep with ack enable set, address match still wakes part
// - after address wake-up SCL held low until flag cleared by writing one
// - data register need not hold the last bus byte after wake-up
// - codes 0x60 own write address, 0x70 general call, both acknowledged
// - arbitration-lost variants report 0x68 own write, 0x78 general call
// - after address states next byte is acked per ack enable
// - last byte sent, master acks: report 0xC8, then send all ones
// - after a terminating state become unaddressed; recognise per ack enable
// - start request in that response issues START once bus is free
module tws_slave
(
	input  wire logic          sys_clk,
	input  wire logic          arst_n,
	input  wire logic          ce,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire tws_pkg::tws_byte_t paddr,
	input  wire tws_pkg::tws_word_t pwdata,
	output tws_pkg::tws_word_t prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          sclIn,
	output logic               sclOut,
	output logic               sclOe,
	input  wire logic          sdaIn,
	output logic               sdaOut,
	output logic               sdaOe,
	input  wire logic          arbLost,
	input  wire logic          deepSleep,
	output logic               wakeReq,
	output logic               startReq,
	output logic               irq
);
	import tws_pkg::*;

	// =============================================
	// declarations
	tws_state_e state_q;
	tws_byte_t  ctrl_q;
	tws_byte_t  addrReg_q;
	tws_byte_t  dataReg_q;
	tws_byte_t  code_q;
	tws_byte_t  shift_q;
	tws_byte_t  rdMux;
	tws_irq_t   iStat_q;
	tws_irq_t   iMask_q;
	tws_irq_t   events;
	logic [1:0] presc_q;
	logic [3:0] bitCnt_q;
	logic [3:0] bitInc;
	logic       isRead_q;
	logic       isGc_q;
	logic       arb_q;
	logic       dataPhase_q;
	logic       ackDrive_q;
	logic       endSlave_q;
	logic       lastTx_q;
	logic       flagSet_q;
	logic       rxLoad_q;
	logic       wakeSet_q;
	logic       sleepLoad_q;
	logic       busBusy_q;
	logic       sclLvl;
	logic       sclRise;
	logic       sclFall;
	logic       sdaLvl;
	logic       sdaRise;
	logic       sdaFall;
	logic       startSeen;
	logic       stopSeen;
	logic       flag;
	logic       ackEn;
	logic       enable;
	logic       setupPh;
	logic       wrEn;
	logic       hitCtrl;
	logic       hitStat;
	logic       hitData;
	logic       hitAddr;
	logic       hitIStat;
	logic       hitIMask;
	logic       hitAny;
	logic       stopCmd;
	logic       flagClr;
	logic       flagFree;
	logic       ownHit;
	logic       gcHit;
	logic       addrHit;
	tws_byte_t  shiftIn;
	tws_byte_t  addrCode;
	tws_byte_t  rxCode;
	tws_byte_t  txCode;

	// =============================================
	// pin synchronisers
	tws_sync u_sclSync
	(
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.ce      (ce),
		.pinIn   (sclIn),
		.level   (sclLvl),
		.rise    (sclRise),
		.fall    (sclFall)
	);

	tws_sync u_sdaSync
	(
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.ce      (ce),
		.pinIn   (sdaIn),
		.level   (sdaLvl),
		.rise    (sdaRise),
		.fall    (sdaFall)
	);

	// =============================================
	// bus conditions and control bits
	assign startSeen = sdaFall & sclLvl;
	assign stopSeen  = sdaRise & sclLvl;
	assign flag      = ctrl_q[`TWS_CTRL_FLAG];
	assign ackEn     = ctrl_q[`TWS_CTRL_ACK];
	assign enable    = ctrl_q[`TWS_CTRL_EN];
	assign bitInc    = bitCnt_q + `TWS_CNT_ONE;
	assign shiftIn   = {shift_q[6:0], sdaLvl};
	// flag pulse is one cycle ahead of the flag bit, so check both
	assign flagFree  = ~flag & ~flagSet_q;

	// =============================================
	// address match; ack enable zero isolates the slave
	assign ownHit  = (shiftIn[7:1] == addrReg_q[7:1]);
	assign gcHit   = (shiftIn[7:1] == `TWS_GC_ADDR) & addrReg_q[0]
		& ~shiftIn[0];
	assign addrHit = ackEn & (ownHit | gcHit);

	// =============================================
	// status code selection
	assign addrCode = isRead_q ? (arb_q ? `TWS_SC_ARB_OWN_R : `TWS_SC_OWN_R)
		: isGc_q ? (arb_q ? `TWS_SC_ARB_GC : `TWS_SC_GC)
		: (arb_q ? `TWS_SC_ARB_OWN_W : `TWS_SC_OWN_W);
	assign rxCode = isGc_q
		? (ackDrive_q ? `TWS_SC_GC_ACK : `TWS_SC_GC_NACK)
		: (ackDrive_q ? `TWS_SC_RX_ACK : `TWS_SC_RX_NACK);
	assign txCode = shift_q[0] ? `TWS_SC_TX_NACK // shift_q[0] holds nack
		: lastTx_q ? `TWS_SC_TX_LAST : `TWS_SC_TX_ACK;

	// =============================================
	// APB decode; writes act in the access phase only
	assign setupPh  = psel & ~penable;
	assign wrEn     = psel & penable & pready & pwrite;
	assign hitCtrl  = (paddr == `TWS_OFS_CTRL);
	assign hitStat  = (paddr == `TWS_OFS_STAT);
	assign hitData  = (paddr == `TWS_OFS_DATA);
	assign hitAddr  = (paddr == `TWS_OFS_ADDR);
	assign hitIStat = (paddr == `TWS_OFS_ISTAT);
	assign hitIMask = (paddr == `TWS_OFS_IMASK);
	assign hitAny   = hitCtrl | hitStat | hitData | hitAddr | hitIStat
		| hitIMask;
	assign stopCmd  = wrEn & hitCtrl & pwdata[`TWS_CTRL_STO];
	assign flagClr  = wrEn & hitCtrl & pwdata[`TWS_CTRL_FLAG];

	// read mux; reserved status bit reads zero
	always_comb
	begin
		rdMux = `TWS_RST_BYTE;
		if (hitCtrl)
			rdMux = ctrl_q;
		else if (hitStat)
			rdMux = {code_q[`TWS_STAT_HI:`TWS_STAT_LO], 1'b0, presc_q};
		else if (hitData)
			rdMux = dataReg_q;
		else if (hitAddr)
			rdMux = addrReg_q;
		else if (hitIStat)
			rdMux = {5'h00, iStat_q};
		else if (hitIMask)
			rdMux = {5'h00, iMask_q};
	end

	// interrupt events
	assign events[`TWS_IRQ_FLAG] = flagSet_q;
	assign events[`TWS_IRQ_STOP] = stopSeen & (state_q != ST_IDLE);
	assign events[`TWS_IRQ_WAKE] = wakeSet_q;

	// =============================================
	// APB answer registered in setup, so one access cycle
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready  <= setupPh;
			pslverr <= setupPh & ~hitAny;
			prdata  <= setupPh ? {24'h00_0000, rdMux} : 32'h0000_0000;
		end
	end

	// control register; hardware flag set wins over a clear
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_q    <= `TWS_RST_BYTE;
			addrReg_q <= `TWS_RST_BYTE;
			presc_q   <= 2'h0;
		end
		else if (ce)
		begin
			if (wrEn & hitCtrl)
			begin
				ctrl_q[6:0] <= {pwdata[6:5], 1'b0, pwdata[3:0]};
			end
			if (flagSet_q)
				ctrl_q[`TWS_CTRL_FLAG] <= 1'b1;
			else if (flagClr)
				ctrl_q[`TWS_CTRL_FLAG] <= 1'b0;
			if (wrEn & hitAddr)
				addrReg_q <= pwdata[7:0];
			if (wrEn & hitStat)
				presc_q <= pwdata[`TWS_PRESC_HI:0];
		end
	end

	// data register; skipped while asleep since no clock reaches it
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			dataReg_q <= `TWS_RST_BYTE;
		else if (ce)
		begin
			if (rxLoad_q & ~sleepLoad_q)
				dataReg_q <= shift_q;
			else if (wrEn & hitData)
				dataReg_q <= pwdata[7:0];
		end
	end

	// sticky interrupt status, write one clears, set wins
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			iStat_q <= `TWS_RST_IRQ;
			iMask_q <= `TWS_RST_IRQ;
			irq     <= 1'b0;
		end
		else if (ce)
		begin
			iStat_q <= events | (iStat_q
				& ~((wrEn & hitIStat) ? pwdata[2:0] : `TWS_RST_IRQ));
			if (wrEn & hitIMask)
				iMask_q <= pwdata[2:0];
			irq <= |(iStat_q & iMask_q);
		end
	end

	// bus busy tracking and start request once bus is free
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			busBusy_q <= 1'b0;
			startReq  <= 1'b0;
		end
		else if (ce)
		begin
			if (startSeen)
				busBusy_q <= 1'b1;
			else if (stopSeen)
				busBusy_q <= 1'b0;
			startReq <= enable & ctrl_q[`TWS_CTRL_STA] & ~busBusy_q
				& (state_q == ST_IDLE);
		end
	end

	// =============================================
	// bus engine: bits sampled on SCL rise, driven after SCL fall
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q     <= ST_IDLE;
			bitCnt_q    <= `TWS_CNT_ZERO;
			shift_q     <= `TWS_RST_BYTE;
			code_q      <= `TWS_SC_IDLE;
			isRead_q    <= 1'b0;
			isGc_q      <= 1'b0;
			arb_q       <= 1'b0;
			dataPhase_q <= 1'b0;
			ackDrive_q  <= 1'b0;
			endSlave_q  <= 1'b0;
			lastTx_q    <= 1'b0;
			flagSet_q   <= 1'b0;
			rxLoad_q    <= 1'b0;
			wakeSet_q   <= 1'b0;
			sleepLoad_q <= 1'b0;
			wakeReq     <= 1'b0;
			sdaOe       <= 1'b0;
			sclOe       <= 1'b0;
		end
		else if (ce)
		begin
			flagSet_q <= 1'b0;
			rxLoad_q  <= 1'b0;
			wakeSet_q <= 1'b0;
			if (arbLost)
				arb_q <= 1'b1;
			if (!enable || stopCmd || stopSeen)
			begin
				state_q <= ST_IDLE;
				sdaOe   <= 1'b0;
				sclOe   <= 1'b0;
				wakeReq <= 1'b0;
			end
			else if (startSeen)
			begin
				// also covers repeated start in mid-transfer
				state_q  <= ST_ADDR;
				bitCnt_q <= `TWS_CNT_ZERO;
				sdaOe    <= 1'b0;
			end
			else
			begin
				case (state_q)
				ST_ADDR:
				begin
					if (sclRise)
					begin
						shift_q  <= shiftIn;
						bitCnt_q <= bitInc;
						if (bitCnt_q == `TWS_LAST_BIT)
						begin
							// a miss leaves the bus alone until next START
							state_q     <= addrHit ? ST_ACK : ST_IDLE;
							isRead_q    <= shiftIn[0];
							isGc_q      <= ~ownHit;
							dataPhase_q <= 1'b0;
							ackDrive_q  <= 1'b1;
							endSlave_q  <= 1'b0;
							wakeReq     <= addrHit & deepSleep;
							wakeSet_q   <= addrHit & deepSleep;
							sleepLoad_q <= deepSleep;
						end
					end
				end
				ST_ACK:
				begin
					if (sclFall && bitCnt_q == `TWS_ACK_BIT)
					begin
						sdaOe    <= ackDrive_q;
						bitCnt_q <= `TWS_ACK_END;
					end
					else if (sclFall && bitCnt_q == `TWS_ACK_END)
					begin
						// stretch SCL until software answers the flag
						sdaOe      <= 1'b0;
						sclOe      <= 1'b1;
						flagSet_q  <= 1'b1;
						rxLoad_q   <= dataPhase_q;
						code_q     <= dataPhase_q ? rxCode : addrCode;
						endSlave_q <= dataPhase_q & ~ackDrive_q;
						state_q    <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					if (flagFree)
					begin
						sclOe    <= 1'b0;
						wakeReq  <= 1'b0;
						arb_q    <= 1'b0;
						bitCnt_q <= `TWS_CNT_ZERO;
						if (endSlave_q)
						begin
							state_q <= ST_IDLE;
							code_q  <= `TWS_SC_IDLE;
						end
						else if (isRead_q)
						begin
							state_q  <= ST_TX;
							shift_q  <= dataReg_q;
							sdaOe    <= ~dataReg_q[7];
							lastTx_q <= ~ackEn;
						end
						else
							state_q <= ST_RX;
					end
				end
				ST_RX:
				begin
					if (sclRise)
					begin
						shift_q  <= shiftIn;
						bitCnt_q <= bitInc;
						if (bitCnt_q == `TWS_LAST_BIT)
						begin
							state_q     <= ST_ACK;
							dataPhase_q <= 1'b1;
							ackDrive_q  <= ackEn;
						end
					end
				end
				ST_TX:
				begin
					if (sclRise)
						bitCnt_q <= bitInc;
					else if (sclFall && bitCnt_q == `TWS_ACK_BIT)
					begin
						sdaOe   <= 1'b0;
						state_q <= ST_TACK;
					end
					else if (sclFall)
					begin
						sdaOe   <= ~shift_q[6];
						shift_q <= {shift_q[6:0], 1'b0};
					end
				end
				ST_TACK:
				begin
					if (sclRise)
						shift_q[0] <= sdaLvl;
					else if (sclFall)
					begin
						// unaddressed after a NACK or the last byte, released SDA reads all ones
						sclOe      <= 1'b1;
						flagSet_q  <= 1'b1;
						code_q     <= txCode;
						endSlave_q <= shift_q[0] | lastTx_q;
						state_q    <= ST_WAIT;
					end
				end
				default:
				begin
					state_q <= ST_IDLE;
					sdaOe   <= 1'b0;
					sclOe   <= 1'b0;
				end
				endcase
			end
		end
	end

	// =============================================
	// open-drain pins only ever pull low
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sdaOut <= 1'b0;
			sclOut <= 1'b0;
		end
		else if (ce)
		begin
			sdaOut <= 1'b0;
			sclOut <= 1'b0;
		end
	end
endmodule : tws_slave

// >>> testbench/tws_bus_master.sv
// two-wire bus master model that drives the link from the far side
`timescale 1ns/1ps
// =============================================
// master model
module tws_bus_master
(
	input  wire logic sys_clk,
	input  wire logic sclLine,
	input  wire logic sdaLine,
	output logic      sclLow,
	output logic      sdaLow
);
	// lines released at start, pull-ups give an idle bus
	initial
	begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end
	// a third of a bit period, 16 ns, four system clocks
	task automatic hp;
		repeat (4) @(posedge sys_clk);
	endtask : hp
	task automatic start;
		hp();
		sdaLow <= 1'b1;
		hp();
		sclLow <= 1'b1;
		hp();
	endtask : start
	// one bit; waits out a stretch before timing the high phase
	task automatic bitx(input logic b, output logic r);
		int i;
		sdaLow <= ~b;
		hp();
		sclLow <= 1'b0;
		for (i = 0; i < 5000 && !sclLine; i++)
			@(posedge sys_clk);
		hp();
		r = sdaLine;
		sclLow <= 1'b1;
		hp();
	endtask : bitx
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int k = 7; k >= 0; k--)
			bitx(d[k], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask : send
	task automatic recv(input logic ackOut, output logic [7:0] d);
		logic r;
		for (int k = 7; k >= 0; k--)
			bitx(1'b1, d[k]);
		bitx(~ackOut, r);
	endtask : recv
	task automatic stop;
		sdaLow <= 1'b1;
		hp();
		sclLow <= 1'b0;
		hp();
		sdaLow <= 1'b0;
		hp();
	endtask : stop
endmodule : tws_bus_master

// >>> testbench/tws_slave_sva.sv
// port checker for the two-wire slave, bound to its top module
`timescale 1ns/1ps
`include "tws_params.svh"
// =============================================
// checker
module tws_slave_sva
(
	input wire logic               sys_clk,
	input wire logic               arst_n,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire tws_pkg::tws_byte_t paddr,
	input wire tws_pkg::tws_word_t pwdata,
	input wire tws_pkg::tws_word_t prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               sclIn,
	input wire logic               sdaIn,
	input wire logic               sclOe,
	input wire logic               deepSleep,
	input wire logic               wakeReq,
	input wire logic               startReq,
	input wire logic               irq
);
	import tws_pkg::*;
	logic [3:0] relCnt_q;
	// decode; the address is still held in the access cycle
	wire done   = psel && penable && pready;
	wire ctrlWr = done && pwrite && paddr == `TWS_OFS_CTRL;
	wire mapped = paddr[1:0] == 2'h0 && paddr <= `TWS_OFS_IMASK;
	// cycles since the last control write, saturating
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			relCnt_q <= 4'hF;
		else if (ctrlWr)
			relCnt_q <= 4'h0;
		else if (relCnt_q != 4'hF)
			relCnt_q <= relCnt_q + 4'h1;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	sequence setupPhase;
		psel && !penable;
	endsequence
	sequence maskOff;
		done && pwrite && paddr == `TWS_OFS_IMASK && pwdata[2:0] == 3'h0;
	endsequence
	chk_apb_answer: assert property (setupPhase |=> pready)
		else $error("no answer one cycle after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held for two cycles");
	chk_error_map: assert property (pready |-> pslverr == !mapped)
		else $error("error response does not match decode");
	chk_stat_layout: assert property (pready && !pwrite &&
		paddr == `TWS_OFS_STAT |-> prdata[31:8] == 24'h0 && !prdata[2])
		else $error("status read has bits outside its layout");
	chk_irq_masked: assert property (maskOff |-> ##2 !irq)
		else $error("interrupt up with all sources masked");
	chk_wake_sleep: assert property ($rose(wakeReq) |-> $past(deepSleep))
		else $error("wake request raised while awake");
	chk_scl_release: assert property ($fell(sclOe) |-> relCnt_q <= 4'h4)
		else $error("clock stretch ended without a flag clear");
	chk_start_free: assert property ($rose(startReq) |-> sclIn && sdaIn)
		else $error("start requested while the bus is busy");
endmodule : tws_slave_sva
bind tws_slave tws_slave_sva tws_slave_sva_i (.sys_clk, .arst_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sclIn,
	.sdaIn, .sclOe, .deepSleep, .wakeReq, .startReq, .irq);

// >>> testbench/tws_slave_tb_top.sv
// self-checking bench for the two-wire slave
`timescale 1ns/1ps
`include "tws_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
// =============================================
// bench top
module tws_slave_tb_top;
	import tws_pkg::*;
	localparam tws_byte_t CODE1 [4] = '{8'h60, 8'h70, 8'h68, 8'h78};
	localparam tws_byte_t CODE2 [4] = '{8'h88, 8'h90, 8'h80, 8'h98};
	logic      sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic      pwrite = 1'b0, arbLost = 1'b0, deepSleep = 1'b0, ce = 1'b1;
	tws_byte_t paddr = 8'h00;
	tws_word_t pwdata = 32'h0, prdata, rd;
	logic      pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, wakeReq;
	logic      startReq, irq, sclLow, sdaLow, ack, slv;
	logic [7:0] b;
	int        errors = 0, cmp_count = 0, cyc = 0;
	// open-drain wires with pull-ups
	wire sclIn = !((sclOe && !sclOut) || sclLow);
	wire sdaIn = !((sdaOe && !sdaOut) || sdaLow);
	always #2 sys_clk = ~sys_clk;
	tws_slave tws_slave_i (.sys_clk, .arst_n, .ce, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sclIn, .sclOut,
		.sclOe, .sdaIn, .sdaOut, .sdaOe, .arbLost, .deepSleep, .wakeReq,
		.startReq, .irq);
	tws_bus_master tws_bus_master_i (.sys_clk, .sclLine(sclIn),
		.sdaLine(sdaIn), .sclLow, .sdaLow);
	// =============================================
	// access tasks; one idle cycle after each so psel never toggles twice
	task automatic apb(input logic w, input tws_byte_t a, input tws_word_t d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (i = 0; i < 16 && pready !== 1'b1; i++)
			@(posedge sys_clk);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		errors += (i == 16);
		@(posedge sys_clk);
	endtask : apb
	task automatic wr(input tws_byte_t a, input tws_word_t d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rchk(input tws_byte_t a, input tws_word_t m, e);
		apb(1'b0, a, 32'h0);
		`CHK(rd & m, e)
	endtask : rchk
	// flag clear, then the sticky events acknowledged
	task automatic clr(input tws_word_t c);
		wr(`TWS_OFS_CTRL, c);
		wr(`TWS_OFS_ISTAT, 32'h7);
	endtask : clr
	task automatic waitUp(input logic sel);
		for (int i = 0; i < 64 && (sel ? startReq : irq) !== 1'b1; i++)
			@(posedge sys_clk);
	endtask : waitUp
	task automatic fin(input string s);
		tws_bus_master_i.stop();
		wr(`TWS_OFS_ISTAT, 32'h7);
		$display("test %s done", s);
	endtask : fin
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	// hang guard, far above the few thousand cycles needed
	always @(posedge sys_clk)
	begin
		cyc++;
		errors += (cyc == 30000);
		if (cyc == 30000)
			end_of_test();
	end
	// =============================================
	// test sequence
	initial
	begin
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		rchk(`TWS_OFS_STAT, 32'hFF, 32'hF8);
		rchk(8'h18, 32'hFFFFFFFF, 32'h0);
		`CHK(slv, 1'b1)
		// prescaler set so later code reads must mask it
		wr(`TWS_OFS_STAT, 32'h3);
		rchk(`TWS_OFS_STAT, 32'hFF, 32'hFB);
		wr(`TWS_OFS_ADDR, 32'h53);
		wr(`TWS_OFS_IMASK, 32'h7);
		wr(`TWS_OFS_CTRL, 32'h44);
		// rows: own or general call, with and without lost arbitration
		for (int n = 0; n < 4; n++)
		begin
			arbLost <= n[1];
			@(posedge sys_clk);
			arbLost <= 1'b0;
			tws_bus_master_i.start();
			tws_bus_master_i.send(n[0] ? 8'h00 : 8'h52, ack);
			waitUp(1'b0);
			`CHK(ack, 1'b1)
			`CHK(irq, 1'b1)
			rchk(`TWS_OFS_STAT, 32'hF8, CODE1[n]);
			clr((n[0] ^ n[1]) ? 32'hC4 : 32'h84);
			tws_bus_master_i.send(tws_byte_t'(8'hA0 + n), ack);
			waitUp(1'b0);
			`CHK(ack, n[0] ^ n[1])
			rchk(`TWS_OFS_STAT, 32'hF8, CODE2[n]);
			rchk(`TWS_OFS_DATA, 32'hFF, 8'hA0 + n);
			clr(32'hC4);
			fin("receive_row");
		end
		// ack enable off isolates; general call disabled is ignored
		wr(`TWS_OFS_CTRL, 32'h04);
		tws_bus_master_i.start();
		tws_bus_master_i.send(8'h52, ack);
		`CHK(ack, 1'b0)
		fin("isolated");
		wr(`TWS_OFS_ADDR, 32'h52);
		wr(`TWS_OFS_CTRL, 32'h44);
		tws_bus_master_i.start();
		tws_bus_master_i.send(8'h00, ack);
		`CHK(ack, 1'b0)
		fin("no_general_call");
		// clock enable low: pins not sampled, own address goes unanswered
		ce <= 1'b0;
		tws_bus_master_i.start();
		tws_bus_master_i.send(8'h52, ack);
		`CHK(ack, 1'b0)
		tws_bus_master_i.stop();
		ce <= 1'b1;
		$display("test frozen done");
		// one byte with ack enable on, last byte with it off, then all ones
		tws_bus_master_i.start();
		tws_bus_master_i.send(8'h53, ack);
		waitUp(1'b0);
		rchk(`TWS_OFS_STAT, 32'hF8, 32'hA8);
		wr(`TWS_OFS_DATA, 32'hC3);
		clr(32'hC4);
		tws_bus_master_i.recv(1'b1, b);
		`CHK(b, 8'hC3)
		waitUp(1'b0);
		rchk(`TWS_OFS_STAT, 32'hF8, 32'hB8);
		wr(`TWS_OFS_DATA, 32'h5A);
		clr(32'h84);
		tws_bus_master_i.recv(1'b1, b);
		`CHK(b, 8'h5A)
		waitUp(1'b0);
		rchk(`TWS_OFS_STAT, 32'hF8, 32'hC8);
		clr(32'hE4);
		tws_bus_master_i.recv(1'b0, b);
		`CHK(b, 8'hFF)
		fin("last_byte");
		waitUp(1'b1);
		`CHK(startReq, 1'b1)
		wr(`TWS_OFS_CTRL, 32'h44);
		// address wake from deep sleep holds the clock low
		deepSleep <= 1'b1;
		tws_bus_master_i.start();
		tws_bus_master_i.send(8'h52, ack);
		waitUp(1'b0);
		`CHK(ack, 1'b1)
		`CHK(wakeReq, 1'b1)
		repeat (40) @(posedge sys_clk);
		`CHK(sclOe, 1'b1)
		wr(`TWS_OFS_IMASK, 32'h0);
		@(posedge sys_clk);
		`CHK(irq, 1'b0)
		wr(`TWS_OFS_IMASK, 32'h7);
		@(posedge sys_clk);
		`CHK(irq, 1'b1)
		deepSleep <= 1'b0;
		// flag clear with the stop request: engine back to idle
		clr(32'hD4);
		`CHK(wakeReq, 1'b0)
		`CHK(sclOe, 1'b0)
		rchk(`TWS_OFS_CTRL, 32'hFF, 32'h44);
		fin("wake");
		end_of_test();
	end
endmodule : tws_slave_tb_top
